// ==== tti_pkg.sv ====
// Shared constants for the two-tier interrupt aggregator
package tti_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_IDENT   = 8'h00;
   localparam logic [7:0] OFF_SUMMARY = 8'h01;
   localparam logic [7:0] OFF_FLAGS   = 8'h02;
   localparam logic [7:0] OFF_MASKS   = 8'h03;
   localparam logic [7:0] OFF_CFG     = 8'h04; // Private threshold settings
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int BIT_KEY   = 5;
   localparam int BIT_TWARN = 4;
   localparam int BIT_SHUTDOWN = 3;
   localparam int BIT_SUPW  = 2;
   localparam int BIT_WDOG  = 1;
   localparam int BIT_INPWR = 0;
   localparam int GRP_SYS   = 3;
   localparam int GRP_CHG   = 2;
   localparam int GRP_BUCK  = 1;
   localparam int GRP_LDO   = 0;
   localparam int NUM_EVT   = 6;
   localparam logic [5:0] MASK_RESET = 6'h3F;
   localparam logic [5:0] FLAG_RESET = 6'h00;
   // ----------------------------------------
   // Timing: key hold time and power-good settle count
   // ----------------------------------------
   localparam int CLK_HZ      = 25_000_000;
   localparam int KEY_HOLD_MS = 5;
   localparam int KEY_HOLD_CYC = (CLK_HZ / 1000) * KEY_HOLD_MS + 1; // Strictly longer than the hold
   localparam int SYNC_SETTLE  = 4; // Edges before the synchronised power-good pin is trusted after reset
endpackage

// ==== tti_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module tti_sync #(
   parameter int    WIDTH = 1,
   parameter logic  INIT  = 1'b0
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   // Stage one is only read by stage two; output follows once two and three agree
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_reg <= {WIDTH{INIT}};
         s2_reg <= {WIDTH{INIT}};
         s3_reg <= {WIDTH{INIT}};
         dout   <= {WIDTH{INIT}};
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               dout[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== tti_key_timer.sv ====
// Power key hold detector: pulses once per press held past the hold time
`timescale 1ns/1ps
`default_nettype none
module tti_key_timer #(
   parameter int HOLD_CYC = tti_pkg::KEY_HOLD_CYC
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic key_n,
   output logic      long_press
);
   logic [$clog2(HOLD_CYC+1)-1:0] cnt_reg;
   // Counts while low; single pulse on reaching the hold, rearmed by release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg    <= '0;
         long_press <= 1'b0;
      end else begin
         long_press <= 1'b0;
         if (key_n) begin
            cnt_reg <= '0;
         end else if (cnt_reg != HOLD_CYC[$bits(cnt_reg)-1:0]) begin
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == HOLD_CYC[$bits(cnt_reg)-1:0] - 1'b1) begin
               long_press <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== tti_aggregator.sv ====
// Two-tier interrupt aggregator with system event group and register port
//
// Operation
// - Identification register read-only: part code bits 7..3, revision 2..0.
// - Events latch into flags; first occurrence asserts the interrupt output.
// - Masked events never drive the interrupt output.
// - Repeat of latched event changes nothing and raises no new interrupt.
// - Several events set all flags; interrupt asserts only on the first.
// - Summary bits: 3 system, 2 charger, 1 buck, 0 linear; 7..4 zero.
// - Summary bit set while any group flag set; clears when all cleared.
// - Summary register read-only; writes ignored.
// - System flags reset to zero; host clears them by writing.
// - Flag 5 set when power key held low longer than 5 ms.
// - Flag 4 set when die temperature reaches the selected warning level.
// - Flag 3 set when die temperature reaches the selected shutdown level.
// - Flag 2 set when supply rail falls below selected warning level.
// - Flag 1 set when watchdog expired since last clear.
// - Flag 0 set when input power good changes either direction.
// - Mask bits 5..0, 1 masks, reset to all ones; 7..6 reserved.
`timescale 1ns/1ps
`default_nettype none
module tti_aggregator #(
   parameter logic [4:0] PART_CODE     = 5'h0_0A, // Arbitrary value
   parameter logic [2:0] REVISION_CODE = 3'h0_2,  // Arbitrary value
   parameter int         KEY_HOLD_CYC  = tti_pkg::KEY_HOLD_CYC
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Event sources from analog monitors and other blocks
   input  wire logic       power_key_n,
   input  wire logic       die_at_warning,
   input  wire logic       die_at_shutdown,
   input  wire logic       supply_below_warning,
   input  wire logic       watchdog_expired,
   input  wire logic       input_power_good,
   input  wire logic       charger_group_pending,
   input  wire logic       buck_group_pending,
   input  wire logic       linear_group_pending,
   // Threshold settings steering the analog comparators
   output logic      [1:0] warning_temperature_level,
   output logic      [2:0] shutdown_temperature_level,
   output logic      [1:0] system_supply_rail,
   // Interrupt to host, active low
   output logic            interrupt_out_n
);
   // ----------------------------------------
   // Input conditioning
   // ----------------------------------------
   logic [5:0] raw_in;
   logic [5:0] syn_in;
   logic       key_pulse;
   logic       pwr_good_d_reg;
   logic       wd_d_reg;

   assign raw_in = {power_key_n, die_at_warning, die_at_shutdown,
                    supply_below_warning, watchdog_expired, input_power_good};

   // All pin inputs cross into clk; key idles high
   tti_sync #(.WIDTH(5), .INIT(1'b0)) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .din    (raw_in[4:0]),
      .dout   (syn_in[4:0])
   );
   tti_sync #(.WIDTH(1), .INIT(1'b1)) u_sync_key (
      .clk    (clk),
      .resetn (resetn),
      .din    (raw_in[5]),
      .dout   (syn_in[5])
   );

   tti_key_timer #(.HOLD_CYC(KEY_HOLD_CYC)) u_key (
      .clk        (clk),
      .resetn     (resetn),
      .key_n      (syn_in[5]),
      .long_press (key_pulse)
   );

   // Previous values, for edge detection of conditions
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwr_good_d_reg <= 1'b0;
         wd_d_reg       <= 1'b0;
      end else begin
         pwr_good_d_reg <= syn_in[0];
         wd_d_reg       <= syn_in[1];
      end
   end

   // Power-good compares start only once the synchroniser has settled, so a pin
   // already high at reset release does not read as a change
   logic [2:0] arm_cnt_reg;
   logic       pwr_armed_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         arm_cnt_reg   <= 3'h0;
         pwr_armed_reg <= 1'b0;
      end else if (arm_cnt_reg == 3'(tti_pkg::SYNC_SETTLE)) begin
         pwr_armed_reg <= 1'b1;
      end else begin
         arm_cnt_reg <= arm_cnt_reg + 3'h1;
      end
   end

   // ----------------------------------------
   // Event vector
   // ----------------------------------------
   logic [5:0] evt;
   always_comb begin
      evt = '0;
      evt[tti_pkg::BIT_KEY]   = key_pulse;
      evt[tti_pkg::BIT_TWARN] = syn_in[4];
      evt[tti_pkg::BIT_SHUTDOWN] = syn_in[3];
      evt[tti_pkg::BIT_SUPW]  = syn_in[2];
      evt[tti_pkg::BIT_WDOG]  = syn_in[1] & ~wd_d_reg;
      evt[tti_pkg::BIT_INPWR] = pwr_armed_reg & (syn_in[0] ^ pwr_good_d_reg);
   end

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic wr_flags;
   logic wr_masks;
   logic wr_cfg;
   assign wr_flags = reg_wr && hit(reg_addr, tti_pkg::OFF_FLAGS);
   assign wr_masks = reg_wr && hit(reg_addr, tti_pkg::OFF_MASKS);
   // Threshold settings sit in a private register just past the map
   assign wr_cfg   = reg_wr && hit(reg_addr, tti_pkg::OFF_CFG);

   // ----------------------------------------
   // Flags, masks and settings
   // ----------------------------------------
   logic [5:0] flags_reg;
   logic [5:0] flags_next;
   logic [5:0] masks_reg;
   logic [6:0] cfg_reg;

   // Set wins over a same-cycle write-one clear
   always_comb begin
      flags_next = flags_reg;
      if (wr_flags) begin
         flags_next = flags_next & ~reg_wdata[5:0];
      end
      flags_next = flags_next | evt;
   end

   // Flags reset to zero; repeats of a latched event leave them as is
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flags_reg <= tti_pkg::FLAG_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Mask register, reserved bits not stored
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         masks_reg <= tti_pkg::MASK_RESET;
      end else if (wr_masks) begin
         masks_reg <= reg_wdata[5:0];
      end
   end

   // Threshold settings: [1:0] warning, [4:2] shutdown, [6:5] supply
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_reg <= 7'h0_0;
      end else if (wr_cfg) begin
         cfg_reg <= reg_wdata[6:0];
      end
   end
   assign warning_temperature_level  = cfg_reg[1:0];
   assign shutdown_temperature_level = cfg_reg[4:2];
   assign system_supply_rail         = cfg_reg[6:5];

   // ----------------------------------------
   // Group summary and interrupt output
   // ----------------------------------------
   logic [3:0] summary;
   always_comb begin
      summary = '0;
      summary[tti_pkg::GRP_SYS]  = |flags_reg;
      summary[tti_pkg::GRP_CHG]  = charger_group_pending;
      summary[tti_pkg::GRP_BUCK] = buck_group_pending;
      summary[tti_pkg::GRP_LDO]  = linear_group_pending;
   end

   // Level follows any unmasked flag: a later event while it is low adds no new edge
   logic pending;
   assign pending = |(flags_reg & ~masks_reg);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         interrupt_out_n <= 1'b1;
      end else begin
         interrupt_out_n <= ~pending;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Registered read; writes to identification and summary fall away
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h0_0;
      end else if (reg_rd) begin
         case (reg_addr)
            tti_pkg::OFF_IDENT:   reg_rdata <= {PART_CODE, REVISION_CODE};
            tti_pkg::OFF_SUMMARY: reg_rdata <= {4'h0, summary};
            tti_pkg::OFF_FLAGS:   reg_rdata <= {2'b00, flags_reg};
            tti_pkg::OFF_MASKS:   reg_rdata <= {2'b00, masks_reg};
            tti_pkg::OFF_CFG:     reg_rdata <= {1'b0, cfg_reg};
            default:              reg_rdata <= 8'h0_0;
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_flag_sticky;
      @(posedge clk) disable iff (!resetn)
      (flags_reg[0] && !wr_flags) |=> flags_reg[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without clear");

   property p_event_sets;
      @(posedge clk) disable iff (!resetn)
      evt[1] |=> flags_reg[1];
   endproperty
   a_event_sets: assert property (p_event_sets) else $error("event not latched");

   property p_clear;
      @(posedge clk) disable iff (!resetn)
      (wr_flags && reg_wdata[3] && !evt[3]) |=> !flags_reg[3];
   endproperty
   a_clear: assert property (p_clear) else $error("write one did not clear");

   property p_masked;
      @(posedge clk) disable iff (!resetn)
      ((flags_reg & ~masks_reg) == 6'h0_0) |=> interrupt_out_n;
   endproperty
   a_masked: assert property (p_masked) else $error("interrupt without unmasked flag");

   property p_assert;
      @(posedge clk) disable iff (!resetn)
      (|(flags_reg & ~masks_reg)) |=> !interrupt_out_n;
   endproperty
   a_assert: assert property (p_assert) else $error("interrupt missing");

   property p_summary;
      @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_addr == tti_pkg::OFF_SUMMARY) |=>
         reg_rdata == {4'h0, $past(flags_reg) != 6'h0_0, $past(charger_group_pending),
                       $past(buck_group_pending), $past(linear_group_pending)};
   endproperty
   a_summary: assert property (p_summary) else $error("system summary wrong");

   property p_ident;
      @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_addr == tti_pkg::OFF_IDENT) |=> reg_rdata == {PART_CODE, REVISION_CODE};
   endproperty
   a_ident: assert property (p_ident) else $error("identification wrong");

   property p_mask_write;
      @(posedge clk) disable iff (!resetn)
      wr_masks |=> {2'b00, masks_reg} == ($past(reg_wdata) & 8'h3F);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask not written");

   property p_pwr_change;
      @(posedge clk) disable iff (!resetn)
      (pwr_armed_reg && $changed(syn_in[0])) |=> flags_reg[0];
   endproperty
   a_pwr_change: assert property (p_pwr_change) else $error("power change missed");

   property p_flags_read;
      @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_addr == tti_pkg::OFF_FLAGS) |=> reg_rdata == {2'b00, $past(flags_reg)};
   endproperty
   a_flags_read: assert property (p_flags_read) else $error("flag read wrong");

   property p_masks_read;
      @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_addr == tti_pkg::OFF_MASKS) |=> reg_rdata == {2'b00, $past(masks_reg)};
   endproperty
   a_masks_read: assert property (p_masks_read) else $error("mask read wrong");

   property p_mask_hold;
      @(posedge clk) disable iff (!resetn)
      !wr_masks |=> $stable(masks_reg);
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write");

   property p_key_single;
      @(posedge clk) disable iff (!resetn)
      key_pulse |=> !key_pulse;
   endproperty
   a_key_single: assert property (p_key_single) else $error("key pulse longer than one cycle");

   property p_cfg_write;
      @(posedge clk) disable iff (!resetn)
      wr_cfg |=> {1'b0, cfg_reg} == ($past(reg_wdata) & 8'h7F);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("threshold settings not written");

   // Every event bit latches, holds and clears the same way; checked bit by bit
   // so a slip in one position of the set/clear merge cannot hide behind another
   for (genvar b = 0; b < tti_pkg::NUM_EVT; b++) begin : g_bit_chk
      property p_bit_set;
         @(posedge clk) disable iff (!resetn)
         evt[b] |=> flags_reg[b];
      endproperty
      a_bit_set: assert property (p_bit_set) else $error("event bit not latched");

      property p_bit_hold;
         @(posedge clk) disable iff (!resetn)
         (flags_reg[b] && !(wr_flags && reg_wdata[b])) |=> flags_reg[b];
      endproperty
      a_bit_hold: assert property (p_bit_hold) else $error("flag bit lost without clear");

      property p_bit_clear;
         @(posedge clk) disable iff (!resetn)
         (wr_flags && reg_wdata[b] && !evt[b]) |=> !flags_reg[b];
      endproperty
      a_bit_clear: assert property (p_bit_clear) else $error("write one left flag bit set");

      property p_bit_quiet;
         @(posedge clk) disable iff (!resetn)
         (!flags_reg[b] && !evt[b]) |=> !flags_reg[b];
      endproperty
      a_bit_quiet: assert property (p_bit_quiet) else $error("flag bit rose without event");
   end

   c_irq:    cover property (@(posedge clk) disable iff (!resetn) $fell(interrupt_out_n));
   c_key:    cover property (@(posedge clk) disable iff (!resetn) key_pulse);
   c_clear:  cover property (@(posedge clk) disable iff (!resetn) $rose(interrupt_out_n));
   c_masked: cover property (@(posedge clk) disable iff (!resetn) (flags_reg != 6'h0_0) && interrupt_out_n);
   c_multi:  cover property (@(posedge clk) disable iff (!resetn) flags_reg[5] && flags_reg[0]);
endmodule
`default_nettype wire

// ==== tti_host_model.sv ====
// Host-side model that drives the register port of the aggregator
`timescale 1ns/1ps
`default_nettype none
module tti_host_model (
   input  wire logic       clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_wdata
);
   // ----------------------------------------
   // Idle state
   // ----------------------------------------
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'h00;
   end
   // ----------------------------------------
   // One strobe cycle, then an idle cycle before the next access
   // ----------------------------------------
   // Idle address and data are inverted so a stale value never looks valid
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = w;
      reg_rd    = !w;
      @(posedge clk);
      #1;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the two-tier interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int HOLD = 20;
   logic       clk;
   logic       resetn;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       reg_wr;
   logic       reg_rd;
   logic       key_n;
   logic       twarn;
   logic       hot_stop;
   logic       supw;
   logic       wdog;
   logic       pgood;
   logic [2:0] grp;
   logic [1:0] warn_lvl;
   logic [2:0] shdn_lvl;
   logic [1:0] sup_lvl;
   logic       interrupt_out_n;
   logic       pend;
   logic [7:0] rnd;
   logic [7:0] exp_q[$];
   int         num_errors;
   int         total_checks;
   int         cyc;

   tti_host_model u_tti_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata));

   tti_aggregator #(.PART_CODE(5'h13), .REVISION_CODE(3'h5), .KEY_HOLD_CYC(HOLD)) u_tti_aggregator (
      .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .power_key_n(key_n), .die_at_warning(twarn),
      .die_at_shutdown(hot_stop), .supply_below_warning(supw), .watchdog_expired(wdog),
      .input_power_good(pgood), .charger_group_pending(grp[2]), .buck_group_pending(grp[1]),
      .linear_group_pending(grp[0]), .warning_temperature_level(warn_lvl),
      .shutdown_temperature_level(shdn_lvl), .system_supply_rail(sup_lvl),
      .interrupt_out_n(interrupt_out_n));

   // ----------------------------------------
   // Clock, timeout and checking helpers
   // ----------------------------------------
   initial clk = 1'b0;
   always #20 clk = ~clk;

   // Generous ceiling: the sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         num_errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (num_errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   // Read data is registered, so look at it half a cycle after the strobe edge
   always @(posedge clk) pend <= reg_rd;
   always @(negedge clk) begin
      if (pend) begin
         cmp("reg_rdata", exp_q.pop_front(), reg_rdata);
      end
   end

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_tti_host_model.access(1'b0, a, 8'h00);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_tti_host_model.access(1'b1, a, d);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk_int(input logic e);
      cmp("interrupt_out_n", {7'h00, e}, {7'h00, interrupt_out_n});
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {twarn, hot_stop, supw, wdog, pgood, grp} = 8'h00;
      key_n        = 1'b1;
      resetn       = 1'b0;
      pend         = 1'b0;
      num_errors   = 0;
      total_checks = 0;
      cyc          = 0;
      void'($urandom(32'h45aa_c97e));
      wt(5);
      resetn = 1'b1;
      // Reset values, unmapped read and read-only places
      rd(tti_pkg::OFF_IDENT, 8'h9D);
      rd(tti_pkg::OFF_SUMMARY, 8'h00);
      rd(tti_pkg::OFF_FLAGS, 8'h00);
      rd(tti_pkg::OFF_MASKS, 8'h3F);
      rd(8'h07, 8'h00);
      chk_int(1'b1);
      wr(tti_pkg::OFF_IDENT, 8'hFF);
      wr(tti_pkg::OFF_SUMMARY, 8'hFF);
      rd(tti_pkg::OFF_IDENT, 8'h9D);
      rd(tti_pkg::OFF_SUMMARY, 8'h00);
      // Masked watchdog expiry latches but stays silent
      wdog = 1'b1;
      wt(8);
      wdog = 1'b0;
      rd(tti_pkg::OFF_FLAGS, 8'h02);
      rd(tti_pkg::OFF_SUMMARY, 8'h08);
      chk_int(1'b1);
      // Unmasking a pending flag pulls the line; zero writes keep, ones clear
      wr(tti_pkg::OFF_MASKS, 8'h00);
      wt(3);
      chk_int(1'b0);
      rd(tti_pkg::OFF_MASKS, 8'h00);
      wr(tti_pkg::OFF_FLAGS, 8'h00);
      rd(tti_pkg::OFF_FLAGS, 8'h02);
      wr(tti_pkg::OFF_FLAGS, 8'h02);
      wt(3);
      chk_int(1'b1);
      rd(tti_pkg::OFF_SUMMARY, 8'h00);
      // A press shorter than the hold time must not count
      key_n = 1'b0;
      wt(HOLD - 8);
      key_n = 1'b1;
      wt(8);
      rd(tti_pkg::OFF_FLAGS, 8'h00);
      // Long press, then more events while the line is already low
      key_n = 1'b0;
      wt(HOLD + 8);
      key_n = 1'b1;
      wt(6);
      chk_int(1'b0);
      rd(tti_pkg::OFF_FLAGS, 8'h20);
      pgood = 1'b1;
      wt(8);
      rd(tti_pkg::OFF_FLAGS, 8'h21);
      pgood = 1'b0;
      wt(8);
      rd(tti_pkg::OFF_FLAGS, 8'h21);
      chk_int(1'b0);
      wr(tti_pkg::OFF_FLAGS, 8'h21);
      wt(3);
      chk_int(1'b1);
      // Level events one at a time, the line re-arming each time
      for (int i = 0; i < 3; i++) begin
         {twarn, hot_stop, supw} = 3'b100 >> i;
         wt(8);
         {twarn, hot_stop, supw} = 3'b000;
         wt(6);
         chk_int(1'b0);
         rd(tti_pkg::OFF_FLAGS, 8'h10 >> i);
         wr(tti_pkg::OFF_FLAGS, 8'h10 >> i);
         wt(3);
         chk_int(1'b1);
      end
      // Random mask decides whether an expiry may pull the line
      rnd = 8'($urandom) & 8'h3F;
      wr(tti_pkg::OFF_MASKS, rnd);
      wdog = 1'b1;
      wt(8);
      wdog = 1'b0;
      chk_int(rnd[1]);
      rd(tti_pkg::OFF_MASKS, rnd);
      wr(tti_pkg::OFF_FLAGS, 8'h02);
      // Random threshold settings reach the comparator outputs
      rnd = 8'($urandom) & 8'h7F;
      wr(tti_pkg::OFF_CFG, rnd);
      wt(2);
      cmp("settings", rnd, {1'b0, sup_lvl, shdn_lvl, warn_lvl});
      // Other groups show in their own summary bits
      for (int i = 0; i < 3; i++) begin
         grp = 3'b001 << i;
         wt(2);
         rd(tti_pkg::OFF_SUMMARY, 8'h01 << i);
      end
      grp = 3'b000;
      // Reset in mid-run with a flag pending and power good already high
      wdog  = 1'b1;
      pgood = 1'b1;
      wt(8);
      wdog   = 1'b0;
      resetn = 1'b0;
      wt(2);
      resetn = 1'b1;
      chk_int(1'b1);
      // Let the synchroniser settle: a high pin must not look like a change
      wt(8);
      rd(tti_pkg::OFF_FLAGS, 8'h00);
      rd(tti_pkg::OFF_MASKS, 8'h3F);
      wt(3);
      end_sim();
   end
endmodule
`default_nettype wire
